//--- core/dtg_top.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module dtg_top
  import dtg_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [REG_W-1:0]  reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [REG_W-1:0]  reg_rdata_o,
  // Sample timing from the shared rate setting
  input  wire logic              sample_stb_i,
  // Consumer source selection
  input  wire logic [SRC_W-1:0]  mixer_source_select_i,
  output logic      [SAMP_W-1:0] sel_samp_o,
  // Sample stream
  output logic                   samp_valid_o,
  input  wire logic              samp_ready_i,
  output logic      [SAMP_W-1:0] gen1_samp_o,
  output logic      [SAMP_W-1:0] gen2_samp_o
);
  logic              gen1_on_q;
  logic              gen2_on_q;
  logic              gen1_dc_select_q;
  logic              gen2_dc_select_q;
  logic [OFS_W-1:0]  ofs_q;
  logic [SAMP_W-1:0] gen1_dc_level_q;
  logic [SAMP_W-1:0] gen2_dc_level_q;
  logic [PH_W-1:0]   acc_q;
  logic [PH_W-1:0]   ph2;
  logic [SAMP_W-1:0] s1;
  logic [SAMP_W-1:0] s2;
  dtg_prod_t         prod_q;
  logic [BUF_W-1:0]  prod_dat_q;
  logic              ovr_q;
  logic              ovr_set;
  logic              ovr_clr;
  logic              buf_in_rdy;
  logic              buf_out_vld;
  logic [BUF_W-1:0]  buf_out_dat;
  logic [REG_W-1:0]  rdata_d;
  logic [REG_W-1:0]  rdata_q;
  logic [SAMP_W-1:0] sel_samp_q;
  logic              wr_ctrl;
  logic              wr_l1h;
  logic              wr_l1l;
  logic              wr_l2h;
  logic              wr_l2l;
  logic              wr_stat;

  // Source decode used by the consumer port only; the checks compare s1 and s2 directly
  function automatic logic [SAMP_W-1:0] src_pick(
    input logic [SRC_W-1:0]  code,
    input logic [SAMP_W-1:0] a,
    input logic [SAMP_W-1:0] b
  );
    if (code == SRC_GEN1) return a;
    if (code == SRC_GEN2) return b;
    return '0;
  endfunction

  // Register write decode
  assign wr_ctrl = ce_i && reg_we_i && (reg_addr_i == REG_CTRL);
  assign wr_l1h  = ce_i && reg_we_i && (reg_addr_i == REG_L1H);
  assign wr_l1l  = ce_i && reg_we_i && (reg_addr_i == REG_L1L);
  assign wr_l2h  = ce_i && reg_we_i && (reg_addr_i == REG_L2H);
  assign wr_l2l  = ce_i && reg_we_i && (reg_addr_i == REG_L2L);
  assign wr_stat = ce_i && reg_we_i && (reg_addr_i == REG_STAT);

  // Control register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen1_on_q        <= CTRL_RST[CTRL_ON1_BIT];
      gen2_on_q        <= CTRL_RST[CTRL_ON2_BIT];
      gen1_dc_select_q <= CTRL_RST[CTRL_DC1_BIT];
      gen2_dc_select_q <= CTRL_RST[CTRL_DC2_BIT];
      ofs_q            <= CTRL_RST[CTRL_OFS_LSB +: OFS_W];
    end else if (wr_ctrl) begin
      gen1_on_q        <= reg_wdata_i[CTRL_ON1_BIT];
      gen2_on_q        <= reg_wdata_i[CTRL_ON2_BIT];
      gen1_dc_select_q <= reg_wdata_i[CTRL_DC1_BIT];
      gen2_dc_select_q <= reg_wdata_i[CTRL_DC2_BIT];
      ofs_q            <= reg_wdata_i[CTRL_OFS_LSB +: OFS_W];
    end
  end

  // Level of generator 1, high word and low byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen1_dc_level_q <= {LVL_HI_RST, LVL_LO_RST};
    end else begin
      if (wr_l1h) gen1_dc_level_q[SAMP_W-1:8] <= reg_wdata_i;
      if (wr_l1l) gen1_dc_level_q[7:0] <= reg_wdata_i[7:0];
    end
  end

  // Level of generator 2, high word and low byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen2_dc_level_q <= {LVL_HI_RST, LVL_LO_RST};
    end else begin
      if (wr_l2h) gen2_dc_level_q[SAMP_W-1:8] <= reg_wdata_i;
      if (wr_l2l) gen2_dc_level_q[7:0] <= reg_wdata_i[7:0];
    end
  end

  // One shared phase keeps the offset exact; it restarts only when both stop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
    end else if (ce_i) begin
      if (!gen1_on_q && !gen2_on_q) acc_q <= '0;
      else acc_q <= acc_q + PH_STEP;
    end
  end

  assign ph2 = acc_q + {ofs_q, {(PH_W - OFS_W){1'b0}}};

  dtg_tone u_gen1 (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .on_i       (gen1_on_q),
    .dc_sel_i   (gen1_dc_select_q),
    .dc_level_i (gen1_dc_level_q),
    .phase_i    (acc_q),
    .samp_o     (s1)
  );

  dtg_tone u_gen2 (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .on_i       (gen2_on_q),
    .dc_sel_i   (gen2_dc_select_q),
    .dc_level_i (gen2_dc_level_q),
    .phase_i    (ph2),
    .samp_o     (s2)
  );

  // Sample capture; a held word waits for buffer room
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prod_q     <= DTG_IDLE;
      prod_dat_q <= '0;
    end else if (ce_i) begin
      unique case (prod_q)
        DTG_IDLE: begin
          if (sample_stb_i) begin
            prod_dat_q <= {s2, s1};
            prod_q     <= DTG_HOLD;
          end
        end
        DTG_HOLD: begin
          if (buf_in_rdy && sample_stb_i) begin
            prod_dat_q <= {s2, s1};
          end else if (buf_in_rdy) begin
            prod_q <= DTG_IDLE;
          end
        end
      endcase
    end
  end

  // Strobe lost while the buffer is full; a new loss beats the clear
  assign ovr_set = ce_i && sample_stb_i && (prod_q == DTG_HOLD) && !buf_in_rdy;
  assign ovr_clr = wr_stat && reg_wdata_i[STAT_OVR_BIT];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_set || (ovr_q && !ovr_clr);
    end
  end

  dtg_fifo2 u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (prod_q == DTG_HOLD),
    .in_ready_o  (buf_in_rdy),
    .in_data_i   (prod_dat_q),
    .out_valid_o (buf_out_vld),
    .out_ready_i (samp_ready_i),
    .out_data_o  (buf_out_dat)
  );

  assign samp_valid_o = buf_out_vld;
  assign gen1_samp_o  = buf_out_dat[SAMP_W-1:0];
  assign gen2_samp_o  = buf_out_dat[BUF_W-1:SAMP_W];

  // Consumer source port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_samp_q <= '0;
    end else if (ce_i) begin
      sel_samp_q <= src_pick(mixer_source_select_i, s1, s2);
    end
  end

  assign sel_samp_o = sel_samp_q;

  // Read mux
  always_comb begin
    rdata_d = '0;
    case (reg_addr_i)
      REG_CTRL: begin
        rdata_d[CTRL_ON1_BIT]            = gen1_on_q;
        rdata_d[CTRL_ON2_BIT]            = gen2_on_q;
        rdata_d[CTRL_DC1_BIT]            = gen1_dc_select_q;
        rdata_d[CTRL_DC2_BIT]            = gen2_dc_select_q;
        rdata_d[CTRL_OFS_LSB +: OFS_W]   = ofs_q;
      end
      REG_L1H: rdata_d = gen1_dc_level_q[SAMP_W-1:8];
      REG_L1L: rdata_d[7:0] = gen1_dc_level_q[7:0];
      REG_L2H: rdata_d = gen2_dc_level_q[SAMP_W-1:8];
      REG_L2L: rdata_d[7:0] = gen2_dc_level_q[7:0];
      REG_STAT: begin
        rdata_d[STAT_RUN1_BIT] = gen1_on_q;
        rdata_d[STAT_RUN2_BIT] = gen2_on_q;
        rdata_d[STAT_OVR_BIT]  = ovr_q;
        rdata_d[STAT_AVL_BIT]  = buf_out_vld;
        rdata_d[STAT_FULL_BIT] = !buf_in_rdy;
      end
      default: rdata_d = '0;
    endcase
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= reg_re_i ? rdata_d : '0;
    end
  end

  assign reg_rdata_o = rdata_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_gen1_off_zero: assert property (
    ce_i && !gen1_on_q |=> s1 == '0)
    else $error("gen1 not zero while off");

  a_gen2_off_zero: assert property (
    ce_i && !gen2_on_q |=> s2 == '0)
    else $error("gen2 not zero while off");

  a_gen1_dc_out: assert property (
    ce_i && gen1_on_q && gen1_dc_select_q |=> s1 == $past(gen1_dc_level_q))
    else $error("gen1 dc level wrong");

  a_gen2_dc_out: assert property (
    ce_i && gen2_on_q && gen2_dc_select_q |=> s2 == $past(gen2_dc_level_q))
    else $error("gen2 dc level wrong");

  a_phase_in_step: assert property (
    ce_i && gen1_on_q && gen2_on_q && !gen1_dc_select_q && !gen2_dc_select_q
      && ofs_q == 2'b00 |=> s2 == s1)
    else $error("zero offset not in phase");

  a_phase_half_turn: assert property (
    ce_i && gen1_on_q && gen2_on_q && !gen1_dc_select_q && !gen2_dc_select_q
      && ofs_q == 2'b10 |=> s2 == SAMP_W'(-s1))
    else $error("half turn offset not inverted");

  a_tone_peak_pos: assert property (
    ce_i && gen1_on_q && !gen1_dc_select_q && acc_q[PH_W-1 -: 6] == 6'h10
      |=> s1 == FS_POS)
    else $error("positive peak not full scale");

  a_tone_peak_neg: assert property (
    ce_i && gen1_on_q && !gen1_dc_select_q && acc_q[PH_W-1 -: 6] == 6'h30
      |=> s1 == FS_NEG)
    else $error("negative peak not full scale");

  a_phase_advance: assert property (
    ce_i && (gen1_on_q || gen2_on_q) |=> acc_q == $past(acc_q) + PH_STEP)
    else $error("phase step wrong");

  a_src_gen1_pick: assert property (
    ce_i && mixer_source_select_i == SRC_GEN1 |=> sel_samp_o == $past(s1))
    else $error("source gen1 not delivered");

  a_src_gen2_pick: assert property (
    ce_i && mixer_source_select_i == SRC_GEN2 |=> sel_samp_o == $past(s2))
    else $error("source gen2 not delivered");

  a_level_hi_write: assert property (
    wr_l1h |=> gen1_dc_level_q[SAMP_W-1:8] == $past(reg_wdata_i))
    else $error("level high word not stored");

  a_ovr_on_loss: assert property (
    ovr_set |=> ovr_q && prod_q == DTG_HOLD)
    else $error("lost strobe not flagged");

  a_level_lo_write: assert property (
    wr_l1l |=> gen1_dc_level_q[7:0] == $past(reg_wdata_i[7:0]))
    else $error("level low byte not stored");

  a_level2_hi_write: assert property (
    wr_l2h |=> gen2_dc_level_q[SAMP_W-1:8] == $past(reg_wdata_i))
    else $error("level 2 high word not stored");

  a_level2_lo_write: assert property (
    wr_l2l |=> gen2_dc_level_q[7:0] == $past(reg_wdata_i[7:0]))
    else $error("level 2 low byte not stored");

  a_ctrl_on_write: assert property (
    wr_ctrl |=> gen1_on_q == $past(reg_wdata_i[CTRL_ON1_BIT])
      && gen2_on_q == $past(reg_wdata_i[CTRL_ON2_BIT]))
    else $error("enable bits not stored");

  a_ctrl_dc_write: assert property (
    wr_ctrl |=> gen1_dc_select_q == $past(reg_wdata_i[CTRL_DC1_BIT])
      && gen2_dc_select_q == $past(reg_wdata_i[CTRL_DC2_BIT]))
    else $error("dc select bits not stored");

  a_ofs_write: assert property (
    wr_ctrl |=> ofs_q == $past(reg_wdata_i[CTRL_OFS_LSB +: OFS_W]))
    else $error("offset field not stored");

  a_src_other_zero: assert property (
    ce_i && mixer_source_select_i != SRC_GEN1 && mixer_source_select_i != SRC_GEN2
      |=> sel_samp_o == '0)
    else $error("unknown source not zero");

  a_phase_restart: assert property (
    ce_i && !gen1_on_q && !gen2_on_q |=> acc_q == '0)
    else $error("phase not restarted while off");

  a_tone_zero_cross: assert property (
    ce_i && gen1_on_q && !gen1_dc_select_q && acc_q[PH_W-1 -: 6] == 6'h00
      |=> s1 == '0)
    else $error("tone not zero at phase start");

  c_both_tones: cover property (
    ce_i && gen1_on_q && gen2_on_q && !gen1_dc_select_q && ofs_q == 2'b01);
  c_dc_output: cover property (ce_i && gen2_on_q && gen2_dc_select_q);
  c_buf_full: cover property (!buf_in_rdy ##1 buf_in_rdy);
  c_overrun: cover property (!ovr_q ##1 ovr_q);
endmodule

//--- core/dtg_pkg.sv
package dtg_pkg;
  // Clock and tone timing
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned TONE_HZ = 1000;
  localparam int          PH_W    = 32;
  localparam logic [PH_W-1:0] PH_STEP =
    PH_W'((64'(TONE_HZ) << PH_W) / 64'(CLK_HZ));
  // Widths and buffer shape
  localparam int ADDR_W = 8;
  localparam int REG_W  = 16;
  localparam int SAMP_W = 24;
  localparam int SRC_W  = 8;
  localparam int BUF_W  = 2 * SAMP_W;
  localparam int BUF_D  = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h20;
  localparam logic [ADDR_W-1:0] REG_L1H  = 8'h21;
  localparam logic [ADDR_W-1:0] REG_L1L  = 8'h22;
  localparam logic [ADDR_W-1:0] REG_L2H  = 8'h23;
  localparam logic [ADDR_W-1:0] REG_L2L  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h25;
  // Control fields
  localparam int CTRL_ON1_BIT = 0;
  localparam int CTRL_ON2_BIT = 1;
  localparam int CTRL_DC1_BIT = 4;
  localparam int CTRL_DC2_BIT = 5;
  localparam int CTRL_OFS_LSB = 8;
  localparam int OFS_W        = 2;
  // Status fields
  localparam int STAT_RUN1_BIT = 0;
  localparam int STAT_RUN2_BIT = 1;
  localparam int STAT_OVR_BIT  = 2;
  localparam int STAT_AVL_BIT  = 3;
  localparam int STAT_FULL_BIT = 4;
  // Reset values
  localparam logic [REG_W-1:0] CTRL_RST   = 16'h0000;
  localparam logic [REG_W-1:0] LVL_HI_RST = 16'h1000;
  localparam logic [7:0]       LVL_LO_RST = 8'h00;
  // Level scale
  localparam logic [SAMP_W-1:0] FS_POS = 24'h100000;
  localparam logic [SAMP_W-1:0] FS_NEG = 24'hf00000;
  // Source-select codes
  localparam logic [SRC_W-1:0] SRC_GEN1 = 8'h04;
  localparam logic [SRC_W-1:0] SRC_GEN2 = 8'h05;
  // Sample hand-off state
  typedef enum logic {DTG_IDLE, DTG_HOLD} dtg_prod_t;
endpackage

//--- core/dtg_fifo2.sv
`timescale 1ns/100ps
module dtg_fifo2
  import dtg_pkg::*;
#(
  parameter int W = BUF_W,
  parameter int D = BUF_D
) (
  // Clock, reset and freeze
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_q != CW'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < D; i++) mem_q[i] <= '0;
      wp_q <= '0;
    end else if (push) begin
      mem_q[wp_q] <= in_data_i;
      wp_q        <= nxt(wp_q);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (pop) rp_q <= nxt(rp_q);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule

//--- core/dtg_tone.sv
`timescale 1ns/100ps
module dtg_tone
  import dtg_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Control
  input  wire logic              on_i,
  input  wire logic              dc_sel_i,
  input  wire logic [SAMP_W-1:0] dc_level_i,
  input  wire logic [PH_W-1:0]   phase_i,
  // Sample
  output logic      [SAMP_W-1:0] samp_o
);
  // Quarter wave, 16 steps; 64 points a period keeps the table tiny
  function automatic logic [SAMP_W-1:0] sin_q(input logic [4:0] k);
    unique case (k)
      5'd0:  return 24'h000000;
      5'd1:  return 24'h01917b;
      5'd2:  return 24'h031f17;
      5'd3:  return 24'h04a503;
      5'd4:  return 24'h061f79;
      5'd5:  return 24'h078ad8;
      5'd6:  return 24'h08e39d;
      5'd7:  return 24'h0a267b;
      5'd8:  return 24'h0b504f;
      5'd9:  return 24'h0c5e41;
      5'd10: return 24'h0d4db3;
      5'd11: return 24'h0e1c5a;
      5'd12: return 24'h0ec837;
      5'd13: return 24'h0f4fa3;
      5'd14: return 24'h0fb14d;
      5'd15: return 24'h0fec3f;
      5'd16: return FS_POS;
      default: return '0;
    endcase
  endfunction

  logic [1:0]        quad;
  logic [3:0]        idx;
  logic [SAMP_W-1:0] mag;
  logic [SAMP_W-1:0] tone;

  assign quad = phase_i[PH_W-1 -: 2];
  assign idx  = phase_i[PH_W-3 -: 4];
  assign mag  = quad[0] ? sin_q(5'd16 - {1'b0, idx}) : sin_q({1'b0, idx});
  assign tone = quad[1] ? SAMP_W'(-mag) : mag;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_o <= '0;
    end else if (ce_i) begin
      if (!on_i) samp_o <= '0;
      else if (dc_sel_i) samp_o <= dc_level_i;
      else samp_o <= tone;
    end
  end
endmodule

//--- verification/dtg_consumer.sv
`timescale 1ns/100ps
module dtg_consumer
  import dtg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Pacing from the bench
  input  wire logic              stall_i,
  // Sample stream
  input  wire logic              valid_i,
  output logic                   ready_o,
  input  wire logic [SAMP_W-1:0] gen1_i,
  input  wire logic [SAMP_W-1:0] gen2_i,
  // What was taken
  output logic      [SAMP_W-1:0] taken_o,
  output logic      [SAMP_W-1:0] last1_o,
  output logic      [SAMP_W-1:0] last2_o
);
  // Ready moves only after an edge; a stall leaves words waiting in the block
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
    end
  end

  // One word per sample instant, taken on every cycle where valid and ready meet
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taken_o <= 24'h000000;
      last1_o <= 24'h000000;
      last2_o <= 24'h000000;
    end else if (valid_i && ready_o) begin
      taken_o <= taken_o + 24'h000001;
      last1_o <= gen1_i;
      last2_o <= gen2_i;
    end
  end
endmodule

//--- verification/dual_tone_dc_generator_test.sv
`timescale 1ns/100ps
module dual_tone_dc_generator_test;
  import dtg_pkg::*;
  logic              clk_i    = 1'b0;
  logic              rst_n_i  = 1'b0;
  logic              ce_i     = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [REG_W-1:0]  reg_wdata = 16'h0000;
  logic              reg_we   = 1'b0;
  logic              reg_re   = 1'b0;
  logic              stb      = 1'b0;
  logic [SRC_W-1:0]  src      = 8'h00;
  logic              stall    = 1'b0;
  logic              ready;
  logic              valid;
  logic [REG_W-1:0]  rdata;
  logic [SAMP_W-1:0] sel_samp;
  logic [SAMP_W-1:0] g1;
  logic [SAMP_W-1:0] g2;
  logic [SAMP_W-1:0] taken;
  logic [SAMP_W-1:0] last1;
  logic [SAMP_W-1:0] last2;
  logic [SAMP_W-1:0] ofs_exp [4];
  int                failures = 0;
  int                checked  = 0;
  int                cycles   = 0;

  always #5 clk_i = ~clk_i;

  dtg_top i_dtg_top (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .ce_i                  (ce_i),
    .reg_addr_i            (reg_addr),
    .reg_wdata_i           (reg_wdata),
    .reg_we_i              (reg_we),
    .reg_re_i              (reg_re),
    .reg_rdata_o           (rdata),
    .sample_stb_i          (stb),
    .mixer_source_select_i (src),
    .sel_samp_o            (sel_samp),
    .samp_valid_o          (valid),
    .samp_ready_i          (ready),
    .gen1_samp_o           (g1),
    .gen2_samp_o           (g2)
  );

  dtg_consumer i_dtg_consumer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .stall_i (stall),
    .valid_i (valid),
    .ready_o (ready),
    .gen1_i  (g1),
    .gen2_i  (g2),
    .taken_o (taken),
    .last1_o (last1),
    .last2_o (last2)
  );

  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [SAMP_W-1:0] seen,
                     input logic [SAMP_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk_i);
    reg_we <= 1'b0;
  endtask

  // Read data is looked at only in the one cycle where it stands
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                        input logic [REG_W-1:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk_i);
    reg_re <= 1'b0;
    #1;
    chk(what, {8'h00, rdata}, {8'h00, exp});
  endtask

  // Selected output is registered behind a control that lags one cycle
  task automatic samp_chk(input string what, input logic [SRC_W-1:0] code,
                          input logic [SAMP_W-1:0] exp);
    @(posedge clk_i);
    src <= code;
    repeat (3) @(posedge clk_i);
    #1;
    chk(what, sel_samp, exp);
  endtask

  task automatic strobe();
    @(posedge clk_i);
    stb <= 1'b1;
    @(posedge clk_i);
    stb <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Longest legal run is three quarters of a tone period plus setup
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    ofs_exp = '{24'h000000, FS_POS, 24'h000000, FS_NEG};
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk("ctrl reset", REG_CTRL, CTRL_RST);
    rd_chk("lvl1 hi reset", REG_L1H, LVL_HI_RST);
    rd_chk("lvl1 lo reset", REG_L1L, 16'h0000);
    rd_chk("lvl2 hi reset", REG_L2H, LVL_HI_RST);
    rd_chk("lvl2 lo reset", REG_L2L, 16'h0000);
    @(posedge clk_i);
    #1;
    chk("rdata after read", {8'h00, rdata}, 24'h000000);
    wr(8'h30, 16'hffff);
    rd_chk("unmapped", 8'h30, 16'h0000);
    wr(REG_CTRL, 16'hffff);
    rd_chk("ctrl fields", REG_CTRL, 16'h0333);
    wr(REG_L1L, 16'hffff);
    rd_chk("lvl1 lo width", REG_L1L, 16'h00ff);
    // Level halves land independently: high word and low byte
    wr(REG_L1H, 16'h1234);
    wr(REG_L1L, 16'h0056);
    wr(REG_L2H, 16'hf000);
    wr(REG_L2L, 16'h0000);
    wr(REG_CTRL, 16'h0033);
    samp_chk("gen1 dc", SRC_GEN1, 24'h123456);
    samp_chk("gen2 dc", SRC_GEN2, FS_NEG);
    samp_chk("no source", 8'h00, 24'h000000);
    // Writes are ignored while the clock enable is low
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    ce_i <= 1'b1;
    rd_chk("frozen ctrl", REG_CTRL, 16'h0033);
    // Stall the consumer until the buffer and the hold stage overflow
    @(posedge clk_i);
    stall <= 1'b1;
    repeat (4) strobe();
    #1;
    chk("head gen1", g1, 24'h123456);
    chk("head gen2", g2, FS_NEG);
    rd_chk("status full", REG_STAT, 16'h001f);
    wr(REG_STAT, 16'h0004);
    rd_chk("status cleared", REG_STAT, 16'h001b);
    @(posedge clk_i);
    stall <= 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    chk("words taken", taken, 24'h000003);
    chk("last gen1", last1, 24'h123456);
    chk("last gen2", last2, FS_NEG);
    chk("drained", {23'h000000, valid}, 24'h000000);
    rd_chk("status empty", REG_STAT, 16'h0003);
    wr(REG_CTRL, 16'h0031);
    samp_chk("gen2 off", SRC_GEN2, 24'h000000);
    wr(REG_L1H, 16'h1000);
    wr(REG_L1L, 16'h0000);
    samp_chk("gen1 plus one", SRC_GEN1, FS_POS);
    // Both off clears the phase, so generator 2 starts at its offset point
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, 16'h0000);
      wr(REG_CTRL, {6'h00, 2'(k), 8'h03});
      samp_chk("gen2 start", SRC_GEN2, ofs_exp[k]);
    end
    wr(REG_CTRL, 16'h0000);
    wr(REG_CTRL, 16'h0001);
    samp_chk("gen1 start", SRC_GEN1, 24'h000000);
    // Quarter, half and three quarters of a 1kHz period, half a table step past
    repeat (25750) @(posedge clk_i);
    #1;
    chk("tone peak", sel_samp, FS_POS);
    repeat (25000) @(posedge clk_i);
    #1;
    chk("tone half period", sel_samp, 24'h000000);
    repeat (25000) @(posedge clk_i);
    #1;
    chk("tone trough", sel_samp, FS_NEG);
    conclude();
  end
endmodule
